/* File: clock_power_ctrl.sv */
// The implementer's own choices: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`include "clk_regs.svh"
module clock_power_ctrl (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic halt_i,
  input wire logic wake_i,
  output logic cpu_clk_en_o,
  output logic sys_clk_en_o,
  output logic slow_clk_en_o,
  output logic tbc_clk_en_o,
  output logic fast_osc_on_o,
  output logic [4:0] fast_freq_mhz_o,
  output clk_pkg::power_mode_t power_mode_o,
  output logic irq_o
);

  // register state
  logic [1:0] fast_freq_sel_reg;
  logic [1:0] fixed_zero_reg;
  clk_pkg::div_sel_t sys_clk_div_sel_reg;
  logic spare_storage_bit_reg;
  logic idle_on_halt_reg;
  logic fast_clock_sel_reg;
  logic keep_sysclk_in_idle_reg;
  logic [`IRQ_BITS-1:0] irq_status_reg;
  logic [`IRQ_BITS-1:0] irq_status_next;
  logic [`IRQ_BITS-1:0] irq_enable_reg;
  logic [`IRQ_BITS-1:0] irq_events;
  logic [`IRQ_BITS-1:0] irq_clear;

  // bus
  logic bus_req;
  logic wr_fire;
  logic [31:0] rd_data;

  // clocking
  clk_pkg::power_mode_t mode_reg;
  logic halt_event_reg;
  logic wake_event_reg;
  logic fast_osc_on_reg;
  logic fast_osc_on_next;
  logic fast_derived;
  logic fast_osc_ready;
  logic fast_ready_rise;
  logic slow_tick;
  logic slow_osc_ready;
  logic slow_ready_rise;
  logic [5:0] presc_reg;
  logic sys_tick;
  logic [4:0] freq_mhz_reg;
  localparam logic [7:0] FREQ_RST_C = `FREQ_RST;
  localparam logic [7:0] MODE_RST_C = `MODE_RST;

  assign bus_req = wb_cyc_i && wb_stb_i;
  assign wr_fire = bus_req && wb_we_i && wb_ack_o && wb_sel_i[0];

  // one wait state, ack dropped the cycle after it was given
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= bus_req && !wb_ack_o;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_dat_o <= 32'h0000_0000;
    else if (bus_req && !wb_ack_o && !wb_we_i)
      wb_dat_o <= rd_data;
  end

  always_comb
  begin
    rd_data = 32'h0000_0000;
    unique case (wb_adr_i)
      `OFS_FREQ:
      begin
        rd_data[`FREQ_SEL_MSB:`FREQ_SEL_LSB] = fast_freq_sel_reg;
        rd_data[`FIXED_ZERO_MSB:`FIXED_ZERO_LSB] = fixed_zero_reg;
      end
      `OFS_MODE:
      begin
        rd_data[`MODE_DIV_MSB:`MODE_DIV_LSB] = sys_clk_div_sel_reg;
        rd_data[`MODE_SPARE] = spare_storage_bit_reg;
        rd_data[`MODE_SLOW_RDY] = slow_osc_ready;
        rd_data[`MODE_FAST_RDY] = fast_osc_ready;
        rd_data[`MODE_IDLE_EN] = idle_on_halt_reg;
        rd_data[`MODE_FAST_SEL] = fast_clock_sel_reg;
      end
      `OFS_KEEP: rd_data[`KEEP_SYSCLK] = keep_sysclk_in_idle_reg;
      `OFS_IRQ_STAT: rd_data[`IRQ_BITS-1:0] = irq_status_reg;
      `OFS_IRQ_EN: rd_data[`IRQ_BITS-1:0] = irq_enable_reg;
      default: rd_data = 32'h0000_0000;
    endcase
  end

  // frequency select register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      fast_freq_sel_reg <= FREQ_RST_C[`FREQ_SEL_MSB:`FREQ_SEL_LSB];
      fixed_zero_reg <= FREQ_RST_C[`FIXED_ZERO_MSB:`FIXED_ZERO_LSB];
    end
    else if (wr_fire && wb_adr_i == `OFS_FREQ)
    begin
      fast_freq_sel_reg <= wb_dat_i[`FREQ_SEL_MSB:`FREQ_SEL_LSB];
      fixed_zero_reg <= wb_dat_i[`FIXED_ZERO_MSB:`FIXED_ZERO_LSB];
    end
  end

  // clock mode register; ready bits are read-only
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sys_clk_div_sel_reg <= MODE_RST_C[`MODE_DIV_MSB:`MODE_DIV_LSB];
      spare_storage_bit_reg <= MODE_RST_C[`MODE_SPARE];
      idle_on_halt_reg <= MODE_RST_C[`MODE_IDLE_EN];
      fast_clock_sel_reg <= MODE_RST_C[`MODE_FAST_SEL];
    end
    else if (wr_fire && wb_adr_i == `OFS_MODE)
    begin
      sys_clk_div_sel_reg <= wb_dat_i[`MODE_DIV_MSB:`MODE_DIV_LSB];
      spare_storage_bit_reg <= wb_dat_i[`MODE_SPARE];
      idle_on_halt_reg <= wb_dat_i[`MODE_IDLE_EN];
      fast_clock_sel_reg <= wb_dat_i[`MODE_FAST_SEL];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      keep_sysclk_in_idle_reg <= 1'b0;
    else if (wr_fire && wb_adr_i == `OFS_KEEP)
      keep_sysclk_in_idle_reg <= wb_dat_i[`KEEP_SYSCLK];
  end

  // interrupt status: a new event wins over a clear in the same cycle
  always_comb
  begin
    irq_events = '0;
    irq_events[`IRQ_FAST_RDY] = fast_ready_rise;
    irq_events[`IRQ_SLOW_RDY] = slow_ready_rise;
    irq_events[`IRQ_HALT] = halt_event_reg;
    irq_events[`IRQ_WAKE] = wake_event_reg;
    irq_clear = '0;
    if (wr_fire && wb_adr_i == `OFS_IRQ_CLR)
    begin
      irq_clear = wb_dat_i[`IRQ_BITS-1:0];
    end
    irq_status_next = (irq_status_reg & ~irq_clear) | irq_events;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      irq_status_reg <= '0;
      irq_enable_reg <= '0;
      irq_o <= 1'b0;
    end
    else
    begin
      irq_status_reg <= irq_status_next;
      if (wr_fire && wb_adr_i == `OFS_IRQ_EN)
      begin
        irq_enable_reg <= wb_dat_i[`IRQ_BITS-1:0];
      end
      irq_o <= |(irq_status_next & irq_enable_reg);
    end
  end

  // halt and wake sequencing
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mode_reg <= clk_pkg::PM_RUN;
      halt_event_reg <= 1'b0;
      wake_event_reg <= 1'b0;
    end
    else
    begin
      halt_event_reg <= 1'b0;
      wake_event_reg <= 1'b0;
      unique case (mode_reg)
        clk_pkg::PM_RUN:
        begin
          if (halt_i)
          begin
            halt_event_reg <= 1'b1;
            if (!idle_on_halt_reg)
            begin
              mode_reg <= clk_pkg::PM_SLEEP;
            end
            else if (keep_sysclk_in_idle_reg)
            begin
              mode_reg <= clk_pkg::PM_IDLE_CLOCK_RUNNING;
            end
            else
            begin
              mode_reg <= clk_pkg::PM_IDLE_CLOCK_STOPPED;
            end
          end
        end
        clk_pkg::PM_SLEEP, clk_pkg::PM_IDLE_CLOCK_STOPPED, clk_pkg::PM_IDLE_CLOCK_RUNNING:
        begin
          if (wake_i)
          begin
            mode_reg <= clk_pkg::PM_RUN;
            wake_event_reg <= 1'b1;
          end
        end
      endcase
    end
  end

  // fast oscillator runs only while a fast-derived clock is in use
  assign fast_derived = fast_clock_sel_reg || (sys_clk_div_sel_reg >= 3'h2);

  always_comb
  begin
    unique case (mode_reg)
      clk_pkg::PM_RUN, clk_pkg::PM_IDLE_CLOCK_RUNNING: fast_osc_on_next = fast_derived;
      clk_pkg::PM_SLEEP, clk_pkg::PM_IDLE_CLOCK_STOPPED: fast_osc_on_next = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      fast_osc_on_reg <= 1'b0;
    else
      fast_osc_on_reg <= fast_osc_on_next;
  end

  always_comb
  begin
    unique case (fast_freq_sel_reg)
      2'h0: freq_mhz_reg = `FREQ_MHZ_8;
      2'h1: freq_mhz_reg = `FREQ_MHZ_16;
      2'h2: freq_mhz_reg = `FREQ_MHZ_12;
      2'h3: freq_mhz_reg = `FREQ_MHZ_8;
    endcase
  end

  // slow oscillator: ungated divider with no control input
  tick_divider #(
    .DIV(`SLOW_DIV)
  ) u_slow_osc (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tick_o(slow_tick)
  );

  ready_timer #(
    .COUNT(`SLOW_READY_TICKS)
  ) u_slow_ready (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(1'b1),
    .tick_i(slow_tick),
    .ready_o(slow_osc_ready),
    .rise_o(slow_ready_rise)
  );

  ready_timer #(
    .COUNT(`FAST_READY_CYCLES)
  ) u_fast_ready (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(fast_osc_on_next),
    .tick_i(1'b1),
    .ready_o(fast_osc_ready),
    .rise_o(fast_ready_rise)
  );

  // fast clock prescaler, runs only on a stable fast oscillator
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !fast_osc_ready)
    begin
      presc_reg <= 6'h00;
    end
    else
    begin
      presc_reg <= presc_reg + 6'h01;
    end
  end

  always_comb
  begin
    if (fast_clock_sel_reg)
    begin
      sys_tick = fast_osc_ready;
    end
    else
    begin
      unique case (sys_clk_div_sel_reg)
        3'h0, 3'h1: sys_tick = slow_tick;
        3'h2: sys_tick = fast_osc_ready && (&presc_reg);
        3'h3: sys_tick = fast_osc_ready && (&presc_reg[4:0]);
        3'h4: sys_tick = fast_osc_ready && (&presc_reg[3:0]);
        3'h5: sys_tick = fast_osc_ready && (&presc_reg[2:0]);
        3'h6: sys_tick = fast_osc_ready && (&presc_reg[1:0]);
        3'h7: sys_tick = fast_osc_ready && presc_reg[0];
      endcase
    end
  end

  // clock enables per mode
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cpu_clk_en_o <= 1'b0;
      sys_clk_en_o <= 1'b0;
      slow_clk_en_o <= 1'b0;
      tbc_clk_en_o <= 1'b0;
    end
    else
    begin
      cpu_clk_en_o <= sys_tick && (mode_reg == clk_pkg::PM_RUN);
      sys_clk_en_o <= sys_tick && (mode_reg == clk_pkg::PM_RUN
                                   || mode_reg == clk_pkg::PM_IDLE_CLOCK_RUNNING);
      slow_clk_en_o <= slow_tick;
      tbc_clk_en_o <= slow_tick && (mode_reg != clk_pkg::PM_SLEEP);
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      fast_freq_mhz_o <= `FREQ_MHZ_8;
      fast_osc_on_o <= 1'b0;
      power_mode_o <= clk_pkg::PM_RUN;
    end
    else
    begin
      fast_freq_mhz_o <= freq_mhz_reg;
      fast_osc_on_o <= fast_osc_on_reg;
      power_mode_o <= mode_reg;
    end
  end

endmodule

/* File: clk_regs.svh */
// Summary of operation
// - fast oscillator frequency field: 00 8MHz, 01 16MHz, 10 12MHz, 11 8MHz.
// - frequency register bits 7, 6, 3 and 2 read as zero.
// - slow 32kHz oscillator runs from power-on; no bit can stop it.
// - fast-clock select at 1 gives the undivided fast clock, ignoring the divider.
// - divider 000/001 slow clock; 010..111 fast clock divided by 64, 32, 16, 8, 4, 2.
// - switching to the slow clock stops the fast oscillator for all of slow mode.
// - fast ready flag clears at power-on and rises once the fast oscillator is stable.
// - fast ready reads low in sleep and stopped idle; high 16 cycles after the wake is taken.
// - slow ready flag reads 0 until the slow oscillator is stable, then 1.
// - clock mode bit 4 stores and returns whatever software writes.
// - halt with idle enable 0 enters sleep; CPU stops, slow clock keeps running.
// - halt with idle enable 1 and keep clock 0 stops CPU and system clock.
// - halt with idle enable 1 and keep clock 1 stops CPU; system clock keeps running.
// - time-base clock runs in all modes except sleep; slow clock runs in all modes.
// - after power-on the fast oscillator runs at its 8MHz default.
`ifndef CLK_REGS_SVH
`define CLK_REGS_SVH

`define OFS_FREQ 8'h00
`define OFS_MODE 8'h04
`define OFS_KEEP 8'h08
`define OFS_IRQ_STAT 8'h0C
`define OFS_IRQ_CLR 8'h10
`define OFS_IRQ_EN 8'h14

`define FREQ_SEL_MSB 5
`define FREQ_SEL_LSB 4
`define FIXED_ZERO_MSB 1
`define FIXED_ZERO_LSB 0
`define FREQ_RST 8'h00

`define MODE_DIV_MSB 7
`define MODE_DIV_LSB 5
`define MODE_SPARE 4
`define MODE_SLOW_RDY 3
`define MODE_FAST_RDY 2
`define MODE_IDLE_EN 1
`define MODE_FAST_SEL 0
`define MODE_RST 8'h03

`define KEEP_SYSCLK 0

`define IRQ_FAST_RDY 0
`define IRQ_SLOW_RDY 1
`define IRQ_HALT 2
`define IRQ_WAKE 3
`define IRQ_BITS 4

`define FREQ_MHZ_8 5'h08
`define FREQ_MHZ_12 5'h0C
`define FREQ_MHZ_16 5'h10

`define CLK_KHZ 40000
`define SLOW_OSC_KHZ 32
`define SLOW_DIV (`CLK_KHZ / `SLOW_OSC_KHZ)
`define FAST_READY_CYCLES 16
`define SLOW_READY_TICKS 4

`endif

/* File: clk_pkg.sv */
package clk_pkg;

  typedef enum logic [1:0] {PM_RUN, PM_SLEEP, PM_IDLE_CLOCK_STOPPED, PM_IDLE_CLOCK_RUNNING} power_mode_t;

  typedef logic [2:0] div_sel_t;

endpackage

/* File: tick_divider.sv */
`timescale 1ns/10ps
module tick_divider #(
  parameter int unsigned DIV = 2
) (
  input wire logic clk_i,
  input wire logic rst_i,
  output logic tick_o
);
  localparam int unsigned W = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [W-1:0] LAST = W'(DIV - 1);

  logic [W-1:0] cnt_reg;

  // free running with no enable
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cnt_reg <= '0;
      tick_o <= 1'b0;
    end
    else
    begin
      tick_o <= (cnt_reg == LAST);
      cnt_reg <= (cnt_reg == LAST) ? '0 : cnt_reg + 1'b1;
    end
  end
endmodule

/* File: ready_timer.sv */
`timescale 1ns/10ps
module ready_timer #(
  parameter int unsigned COUNT = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic run_i,
  input wire logic tick_i,
  output logic ready_o,
  output logic rise_o
);
  localparam int unsigned W = $clog2(COUNT + 1);
  localparam logic [W-1:0] LAST = W'(COUNT - 1);

  logic [W-1:0] cnt_reg;

  // ready is lost at once when the oscillator stops
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !run_i)
    begin
      cnt_reg <= '0;
      ready_o <= 1'b0;
      rise_o <= 1'b0;
    end
    else
    begin
      rise_o <= 1'b0;
      if (tick_i && !ready_o)
      begin
        cnt_reg <= cnt_reg + 1'b1;
        if (cnt_reg == LAST)
        begin
          ready_o <= 1'b1;
          rise_o <= 1'b1;
        end
      end
    end
  end
endmodule

/* File: clock_power_ctrl_chk.sv */
`timescale 1ns/10ps
module clock_power_ctrl_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic halt_i,
  input wire logic wake_i,
  input wire logic cpu_clk_en_o,
  input wire logic sys_clk_en_o,
  input wire logic slow_clk_en_o,
  input wire logic tbc_clk_en_o,
  input wire logic fast_osc_on_o,
  input wire logic [4:0] fast_freq_mhz_o,
  input wire clk_pkg::power_mode_t power_mode_o
);
  logic [10:0] gap_reg;
  always_ff @(posedge clk_i)
  begin
    if (rst_i || slow_clk_en_o)
      gap_reg <= 11'h000;
    else
      gap_reg <= gap_reg + 11'h001;
  end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  sequence halt_s;
    halt_i && power_mode_o == clk_pkg::PM_RUN;
  endsequence
  sequence wake_s;
    wake_i && power_mode_o != clk_pkg::PM_RUN;
  endsequence
  ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack");
  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  halt_enter_a: assert property (halt_s |-> ##2 power_mode_o != clk_pkg::PM_RUN)
    else $error("halt not taken");
  wake_exit_a: assert property (wake_s |-> ##2 power_mode_o == clk_pkg::PM_RUN)
    else $error("wake not taken");
  cpu_stop_a: assert property (power_mode_o != clk_pkg::PM_RUN |-> !cpu_clk_en_o)
    else $error("cpu clock in halt");
  sys_stop_a: assert property (power_mode_o inside {clk_pkg::PM_SLEEP, clk_pkg::PM_IDLE_CLOCK_STOPPED}
    |-> !sys_clk_en_o)
    else $error("system clock in stop");
  tbc_sleep_a: assert property (power_mode_o == clk_pkg::PM_SLEEP |-> !tbc_clk_en_o)
    else $error("time base in sleep");
  slow_live_a: assert property (gap_reg < 11'h4EC)
    else $error("slow clock stalled");
  osc_sleep_a: assert property (power_mode_o == clk_pkg::PM_SLEEP &&
    $past(power_mode_o) == clk_pkg::PM_SLEEP |-> !fast_osc_on_o)
    else $error("fast osc on in sleep");
  freq_code_a: assert property (fast_freq_mhz_o inside {5'h08, 5'h0C, 5'h10})
    else $error("bad frequency");
endmodule
bind clock_power_ctrl clock_power_ctrl_chk clock_power_ctrl_chk_inst (.clk_i(clk_i),
  .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .halt_i(halt_i), .wake_i(wake_i), .cpu_clk_en_o(cpu_clk_en_o),
  .sys_clk_en_o(sys_clk_en_o), .slow_clk_en_o(slow_clk_en_o), .tbc_clk_en_o(tbc_clk_en_o),
  .fast_osc_on_o(fast_osc_on_o), .fast_freq_mhz_o(fast_freq_mhz_o),
  .power_mode_o(power_mode_o));

/* File: cpu_model.sv */
`timescale 1ns/10ps
module cpu_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic halt_req_i,
  input wire logic wake_req_i,
  output logic halt_o,
  output logic wake_o
);
  // a request held high leaves as a single-cycle pulse on every other cycle
  always_ff @(posedge clk_i)
  begin
    halt_o <= !rst_i && halt_req_i && !halt_o;
    wake_o <= !rst_i && wake_req_i && !wake_o;
  end
endmodule

/* File: tb_clock_power_ctrl.sv */
`timescale 1ns/10ps
`include "clk_regs.svh"
module tb_clock_power_ctrl;
  logic clk_i = 0;
  logic rst_i = 1;
  logic cyc = 0;
  logic stb = 0;
  logic we = 0;
  logic hreq = 0;
  logic wreq = 0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0000_0000;
  logic [31:0] rdat;
  logic [31:0] q;
  logic halt, wake, ack, cpu_en, sys_en, slow_en, tbc_en, osc_on, irq;
  logic [4:0] mhz;
  clk_pkg::power_mode_t mode;
  logic [15:0] lfsr = 16'h766E;
  int n_fail = 0;
  int comparisons = 0;
  int cycles = 0;
  int c, s, e, t;
  clock_power_ctrl clock_power_ctrl_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .halt_i(halt), .wake_i(wake), .cpu_clk_en_o(cpu_en),
    .sys_clk_en_o(sys_en), .slow_clk_en_o(slow_en), .tbc_clk_en_o(tbc_en),
    .fast_osc_on_o(osc_on), .fast_freq_mhz_o(mhz), .power_mode_o(mode), .irq_o(irq));
  cpu_model cpu_model_inst (.clk_i(clk_i), .rst_i(rst_i), .halt_req_i(hreq),
    .wake_req_i(wreq), .halt_o(halt), .wake_o(wake));
  initial forever #12.5 clk_i = ~clk_i;
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      n_fail++;
      give_verdict();
    end
  end
  function logic [15:0] nxt(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  function int mhz_of(input int k);
    return k == 1 ? 16 : k == 2 ? 12 : 8;
  endfunction
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task xfer(input logic [7:0] a, input logic w, input logic [7:0] d);
    @(posedge clk_i);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    dat <= {24'h00_0000, d};
    do @(posedge clk_i); while (ack !== 1'b1);
    q = rdat;
    cyc <= 0;
    stb <= 0;
    we <= 0;
  endtask
  task cnt(input int n);
    c = 0;
    s = 0;
    t = 0;
    repeat (n)
    begin
      @(posedge clk_i);
      c += cpu_en;
      s += sys_en;
      t += tbc_en;
    end
  endtask
  task pulse(input logic h);
    @(posedge clk_i);
    if (h)
      hreq <= 1;
    else
      wreq <= 1;
    @(posedge clk_i);
    hreq <= 0;
    wreq <= 0;
  endtask
  task wait_fast;
    do xfer(`OFS_MODE, 0, 8'h00); while (q[2] !== 1'b1);
  endtask
  task give_verdict;
    if (n_fail == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    repeat (16) @(posedge clk_i);
    rst_i <= 0;
    chk(32'(mhz), 32'h0000_0008);
    xfer(`OFS_FREQ, 0, 8'h00);
    chk(q, 32'h0000_0000);
    wait_fast();
    chk(q, 32'h0000_0007);
    repeat (5200) @(posedge clk_i);
    xfer(`OFS_MODE, 0, 8'h00);
    chk(q, 32'h0000_000F);
    for (int i = 0; i < 4; i++)
    begin
      lfsr = nxt(lfsr);
      xfer(`OFS_FREQ, 1, {lfsr[7:6], 2'(i), lfsr[3:2], 2'b00});
      xfer(`OFS_FREQ, 0, 8'h00);
      chk(q, 32'(i << 4));
      chk(32'(mhz), mhz_of(i));
    end
    lfsr = nxt(lfsr);
    xfer(`OFS_MODE, 1, {lfsr[7:5], lfsr[0], 4'h1});
    xfer(`OFS_MODE, 0, 8'h00);
    chk(q, 32'({lfsr[7:5], lfsr[0], 4'hD}));
    cnt(64);
    chk(c, 64);
    for (int d = 2; d < 8; d++)
    begin
      xfer(`OFS_MODE, 1, {3'(d), 5'h00});
      repeat (8) @(posedge clk_i);
      cnt(768);
      e = 768 / (256 >> d);
      chk(32'(c >= e - 1 && c <= e + 1), 1);
    end
    xfer(`OFS_MODE, 1, {2'b00, lfsr[1], 5'h00});
    repeat (8) @(posedge clk_i);
    chk(32'(osc_on), 0);
    cnt(2500);
    chk(32'(c >= 1 && c <= 3), 1);
    xfer(`OFS_MODE, 1, 8'h03);
    wait_fast();
    xfer(8'h20, 1, lfsr[15:8]);
    xfer(8'h20, 0, 8'h00);
    chk(q, 0);
    for (int i = 0; i < 3; i++)
    begin
      xfer(`OFS_KEEP, 1, 8'(i == 2));
      xfer(`OFS_MODE, 1, {6'h00, i > 0, 1'b1});
      xfer(`OFS_IRQ_CLR, 1, 8'h0F);
      xfer(`OFS_IRQ_EN, 1, i > 0 ? 8'h04 : 8'h00);
      pulse(1);
      repeat (3) @(posedge clk_i);
      chk(32'(mode), i + 1);
      chk(32'(irq), 32'(i > 0));
      cnt(1250);
      chk(c, 0);
      chk(s, i == 2 ? 1250 : 0);
      chk(t, 32'(i > 0));
      xfer(`OFS_IRQ_STAT, 0, 8'h00);
      chk(q, 32'h0000_0004);
      xfer(`OFS_MODE, 0, 8'h00);
      chk(32'(q[2]), 32'(i == 2));
      xfer(`OFS_IRQ_CLR, 1, 8'h04);
      repeat (2) @(posedge clk_i);
      chk(32'(irq), 0);
      pulse(0);
      repeat (10) @(posedge clk_i);
      chk(32'(mode), 0);
      xfer(`OFS_MODE, 0, 8'h00);
      chk(32'(q[2]), 32'(i == 2));
      repeat (14) @(posedge clk_i);
      xfer(`OFS_MODE, 0, 8'h00);
      chk(32'(q[2]), 1);
      xfer(`OFS_IRQ_STAT, 0, 8'h00);
      chk(q, i == 2 ? 32'h0000_0008 : 32'h0000_0009);
    end
    give_verdict();
  end
endmodule
